// [design/ddr_sdram_command_timing.sv]
// What this block does
// - column address bit ten selects auto precharge
// - later write truncates earlier write burst
// - read of eight may be cut by precharge
// - burst elements follow programmed burst order
// - power-down kind follows open rows
// - data, mask and strobe ignored outside bursts
`timescale 1ns/1ns
`default_nettype none

module ddr_sdram_command_timing
    import ddr_cmd_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic                ck,
    input  wire logic                cke,
    input  wire logic                csN,
    input  wire logic                rasN,
    input  wire logic                casN,
    input  wire logic                weN,
    input  wire logic [1:0]          ba,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic                upperByteMask,
    input  wire logic                lowerByteMask,
    input  wire logic [DQ_W-1:0]     dqIn,
    output logic      [DQ_W-1:0]     dqOut,
    output logic                     dqOe,
    input  wire logic                dqsIn,
    output logic                     dqsOut,
    output logic                     dqsOe,
    output logic      [BANKS-1:0]    bankOpenSys,
    output logic                     prePowerDownSys,
    output logic                     actPowerDownSys,
    output logic                     selfRefreshSys,
    output logic                     dllEnabledSys,
    output logic      [REFCNT_W-1:0] refreshCount
);

    // address of burst element k from the start column
    function automatic logic [COL_W-1:0] burstCol(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] k,
        input logic [2:0]       bl,
        input logic             inter
    );
        logic [COL_W-1:0] mask;
        logic [COL_W-1:0] step;
        mask = (bl == BL_8) ? 3'h7 : ((bl == BL_4) ? 3'h3 : 3'h1);
        step = inter ? (start ^ k) : COL_W'(start + k);
        return (start & ~mask) | (step & mask);
    endfunction

    // index of the last element pair of a burst
    function automatic logic [1:0] lastPair(input logic [2:0] bl);
        return (bl == BL_8) ? 2'h3 : ((bl == BL_4) ? 2'h1 : 2'h0);
    endfunction

    // ---------------- link domain, clocked by ck ----------------
    logic                 rstMeta_reg;
    logic                 linkReset_reg;
    logic                 ckePrev_reg;
    logic [ADDR_W-1:0]    mode_reg;
    logic                 dllOn_reg;
    logic [BANKS-1:0]     bankOpen_reg;
    pwr_state_e           pwr_reg;
    logic                 wrActive_reg;
    logic [1:0]           wrBank_reg;
    logic [COL_W-1:0]     wrStart_reg;
    logic                 wrAp_reg;
    logic [1:0]           wrPair_reg;
    logic                 capValid_reg;
    logic [DQ_W-1:0]      evenData_reg;
    logic [1:0]           evenMask_reg;
    logic [DQ_W-1:0]      oddData_reg;
    logic [1:0]           oddMask_reg;
    logic [MEM_AW-1:0]    capAddr0_reg;
    logic [MEM_AW-1:0]    capAddr1_reg;
    logic                 rdActive_reg;
    logic [1:0]           rdBank_reg;
    logic [COL_W-1:0]     rdStart_reg;
    logic                 rdAp_reg;
    logic [1:0]           rdPair_reg;
    logic                 s1Valid_reg;
    logic                 s2Valid_reg;
    logic                 s3Valid_reg;
    logic [DQ_W-1:0]      s2Even_reg;
    logic [DQ_W-1:0]      s2Odd_reg;
    logic [DQ_W-1:0]      s3Even_reg;
    logic [DQ_W-1:0]      s3Odd_reg;
    logic                 refreshTgl_reg;
    logic [STATUS_W-1:0]  statusLink_reg;
    logic [2:0]           cmd;
    logic                 cmdLive;
    logic                 doAct;
    logic                 doRd;
    logic                 doWr;
    logic                 doPre;
    logic                 doRef;
    logic                 doMrs;
    logic                 doBst;
    logic                 srEntry;
    logic                 pdEntry;
    logic                 wrStop;
    logic                 rdStop;
    logic                 wrLast;
    logic                 rdLast;
    logic                 cl3;
    logic                 inter;
    logic [2:0]           bl;
    logic [DQ_W-1:0]      memRdA;
    logic [DQ_W-1:0]      memRdB;
    logic                 outValid;
    logic                 preamble;
    logic [DQ_W-1:0]      outEven;
    logic [DQ_W-1:0]      outOdd;

    // reset reaches the link clock through two flops
    always_ff @(posedge ck) begin
        rstMeta_reg   <= reset;
        linkReset_reg <= rstMeta_reg;
    end

    // command decode; cke must be high now and on the previous edge
    assign cmd     = {rasN, casN, weN};
    assign cmdLive = ckePrev_reg && cke && !csN && (pwr_reg == PWR_RUN);
    assign doAct   = cmdLive && (cmd == CMD_ACT);
    assign doRd    = cmdLive && (cmd == CMD_RD) && bankOpen_reg[ba];
    assign doWr    = cmdLive && (cmd == CMD_WR) && bankOpen_reg[ba];
    assign doPre   = cmdLive && (cmd == CMD_PRE);
    assign doRef   = cmdLive && (cmd == CMD_REF);
    assign doMrs   = cmdLive && (cmd == CMD_MRS);
    assign doBst   = cmdLive && (cmd == CMD_BST);
    assign srEntry = ckePrev_reg && !cke && !csN && (cmd == CMD_REF)
                     && (pwr_reg == PWR_RUN);
    // bursts still running are the controller's fault
    assign pdEntry = ckePrev_reg && !cke && !srEntry
                     && (pwr_reg == PWR_RUN);

    assign bl    = mode_reg[BL_LSB +: 3];
    assign inter = mode_reg[BT_BIT];
    assign cl3   = (mode_reg[CL_LSB +: 3] == CL_3)
                   || (mode_reg[CL_LSB +: 3] == CL_25);

    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            ckePrev_reg <= 1'b0;
        end else begin
            ckePrev_reg <= cke;
        end
    end

    // mode and extended mode registers
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            mode_reg  <= MODE_RESET;
            dllOn_reg <= DLL_ON_RESET;
        end else if (doMrs && (ba == MRS_BANK)) begin
            mode_reg <= addr;
        end else if (doMrs && (ba == EMRS_BANK)) begin
            dllOn_reg <= !addr[DLL_OFF_BIT];
        end
    end

    // power state; kind of power-down from rows open at entry
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            pwr_reg <= PWR_RUN;
        end else begin
            case (pwr_reg)
                PWR_RUN: begin
                    if (srEntry) begin
                        pwr_reg <= PWR_SELF;
                    end else if (pdEntry) begin
                        pwr_reg <= (|bankOpen_reg) ? PWR_ACT_DOWN
                                                   : PWR_PRE_DOWN;
                    end
                end
                PWR_PRE_DOWN, PWR_ACT_DOWN, PWR_SELF: begin
                    if (cke) begin
                        pwr_reg <= PWR_RUN;
                    end
                end
                default: pwr_reg <= PWR_RUN;
            endcase
        end
    end

    // bank open/idle; precharge with bit ten closes every bank
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            bankOpen_reg <= '0;
        end else begin
            if (doPre && addr[AP_BIT]) begin
                bankOpen_reg <= '0;
            end else if (doPre) begin
                bankOpen_reg[ba] <= 1'b0;
            end
            if (wrLast && wrAp_reg) begin
                bankOpen_reg[wrBank_reg] <= 1'b0;
            end
            if (rdLast && rdAp_reg) begin
                bankOpen_reg[rdBank_reg] <= 1'b0;
            end
            if (doAct) begin
                bankOpen_reg[ba] <= 1'b1;
            end
        end
    end

    // write burst; a read, precharge or new write ends it here
    assign wrStop = doRd || doPre || doWr;
    assign wrLast = wrActive_reg && !wrStop
                    && (wrPair_reg == lastPair(bl));

    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            wrActive_reg <= 1'b0;
            wrBank_reg   <= 2'h0;
            wrStart_reg  <= '0;
            wrAp_reg     <= 1'b0;
            wrPair_reg   <= 2'h0;
        end else if (doWr) begin
            wrActive_reg <= 1'b1;
            wrBank_reg   <= ba;
            wrStart_reg  <= addr[COL_W-1:0];
            wrAp_reg     <= addr[AP_BIT];
            wrPair_reg   <= 2'h0;
        end else if (wrStop || wrLast) begin
            wrActive_reg <= 1'b0;
        end else if (wrActive_reg) begin
            wrPair_reg <= wrPair_reg + 2'h1;
        end
    end

    // even element on the rising edge, with addresses of the pair
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            capValid_reg <= 1'b0;
        end else begin
            capValid_reg <= wrActive_reg && !wrStop;
        end
    end

    always_ff @(posedge ck) begin
        if (wrActive_reg && !wrStop) begin
            evenData_reg <= dqIn;
            evenMask_reg <= {upperByteMask, lowerByteMask};
            capAddr0_reg <= {wrBank_reg, burstCol(wrStart_reg,
                             {wrPair_reg, 1'b0}, bl, inter)};
            capAddr1_reg <= {wrBank_reg, burstCol(wrStart_reg,
                             {wrPair_reg, 1'b1}, bl, inter)};
        end
    end

    // odd element on the falling edge; a pair commits at the next
    // rising edge, which is where recovery timing starts
    always_ff @(negedge ck) begin
        oddData_reg <= dqIn;
        oddMask_reg <= {upperByteMask, lowerByteMask};
    end

    // read burst; write, terminate or precharge of this bank stop it
    assign rdStop = doWr || doBst
                    || (doPre && (addr[AP_BIT] || (ba == rdBank_reg)));
    assign rdLast = rdActive_reg && !rdStop && !doRd
                    && (rdPair_reg == lastPair(bl));

    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            rdActive_reg <= 1'b0;
            rdBank_reg   <= 2'h0;
            rdStart_reg  <= '0;
            rdAp_reg     <= 1'b0;
            rdPair_reg   <= 2'h0;
        end else if (doRd) begin
            rdActive_reg <= 1'b1;
            rdBank_reg   <= ba;
            rdStart_reg  <= addr[COL_W-1:0];
            rdAp_reg     <= addr[AP_BIT];
            rdPair_reg   <= 2'h0;
        end else if (rdStop || rdLast) begin
            rdActive_reg <= 1'b0;
        end else if (rdActive_reg) begin
            rdPair_reg <= rdPair_reg + 2'h1;
        end
    end

    // burst store; the mask bits block writes lane by lane
    ddr_burst_mem u_mem (
        .clk     (ck),
        .wrEnA   (capValid_reg),
        .wrAddrA (capAddr0_reg),
        .wrDataA (evenData_reg),
        .byteEnA (~evenMask_reg),
        .wrEnB   (capValid_reg),
        .wrAddrB (capAddr1_reg),
        .wrDataB (oddData_reg),
        .byteEnB (~oddMask_reg),
        .rdAddrA ({rdBank_reg, burstCol(rdStart_reg,
                   {rdPair_reg, 1'b0}, bl, inter)}),
        .rdAddrB ({rdBank_reg, burstCol(rdStart_reg,
                   {rdPair_reg, 1'b1}, bl, inter)}),
        .rdDataA (memRdA),
        .rdDataB (memRdB)
    );

    // read pipeline; latency 2.5 runs as 3, the store adds one cycle
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            s1Valid_reg <= 1'b0;
            s2Valid_reg <= 1'b0;
            s3Valid_reg <= 1'b0;
        end else begin
            s1Valid_reg <= rdActive_reg && !rdStop;
            s2Valid_reg <= s1Valid_reg;
            s3Valid_reg <= s2Valid_reg;
        end
    end

    always_ff @(posedge ck) begin
        s2Even_reg <= memRdA;
        s2Odd_reg  <= memRdB;
        s3Even_reg <= s2Even_reg;
        s3Odd_reg  <= s2Odd_reg;
    end

    assign outValid = cl3 ? s3Valid_reg : s2Valid_reg;
    assign preamble = (cl3 ? s2Valid_reg : s1Valid_reg) && !outValid;
    assign outEven  = cl3 ? s3Even_reg : s2Even_reg;
    assign outOdd   = cl3 ? s3Odd_reg : s2Odd_reg;

    // pins driven only for read data; ck picks the half element,
    // which keeps the pair in one flop stage at the cost of a
    // clock-to-data path that the pad timing must cover
    assign dqOut  = ck ? outEven : outOdd;
    assign dqOe   = outValid;
    assign dqsOut = outValid && ck;
    assign dqsOe  = outValid || preamble;

    // refresh events leave as a toggle; open banks are not checked
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            refreshTgl_reg <= 1'b0;
        end else if (doRef) begin
            refreshTgl_reg <= !refreshTgl_reg;
        end
    end

    // status is flopped before crossing so no decode glitch escapes
    always_ff @(posedge ck) begin
        if (linkReset_reg) begin
            statusLink_reg <= '0;
        end else begin
            statusLink_reg <= {dllOn_reg,
                               pwr_reg == PWR_SELF,
                               pwr_reg == PWR_ACT_DOWN,
                               pwr_reg == PWR_PRE_DOWN,
                               bankOpen_reg};
        end
    end

    // ---------------- system domain, clocked by clk_sys ----------------
    logic [STATUS_W-1:0] statusMeta_reg;
    logic [STATUS_W-1:0] statusSync_reg;
    logic [2:0]          tglSync_reg;

    // independent level bits, two flops each
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            statusMeta_reg <= '0;
            statusSync_reg <= '0;
        end else begin
            statusMeta_reg <= statusLink_reg;
            statusSync_reg <= statusMeta_reg;
        end
    end

    assign bankOpenSys     = statusSync_reg[BANKS-1:0];
    assign prePowerDownSys = statusSync_reg[BANKS];
    assign actPowerDownSys = statusSync_reg[BANKS+1];
    assign selfRefreshSys  = statusSync_reg[BANKS+2];
    assign dllEnabledSys   = statusSync_reg[BANKS+3];

    // refresh toggle: two flops, then an edge detect on the third
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tglSync_reg  <= 3'h0;
            refreshCount <= '0;
        end else begin
            tglSync_reg <= {tglSync_reg[1:0], refreshTgl_reg};
            if (tglSync_reg[2] != tglSync_reg[1]) begin
                refreshCount <= refreshCount + 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// [design/ddr_cmd_pkg.sv]
package ddr_cmd_pkg;

    // widths of the pins and of the little burst store
    localparam int ADDR_W   = 13;
    localparam int DQ_W     = 16;
    localparam int BANKS    = 4;
    localparam int COL_W    = 3;
    localparam int MEM_AW   = 5;
    localparam int STATUS_W = 8;
    localparam int REFCNT_W = 16;

    // command codes as {rasN, casN, weN}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // address fields
    localparam int AP_BIT      = 10;
    localparam int BL_LSB      = 0;
    localparam int BT_BIT      = 3;
    localparam int CL_LSB      = 4;
    localparam int DLL_OFF_BIT = 0;
    localparam logic [1:0] MRS_BANK  = 2'h0;
    localparam logic [1:0] EMRS_BANK = 2'h1;

    // burst length and latency codes
    localparam logic [2:0] BL_2  = 3'h1;
    localparam logic [2:0] BL_4  = 3'h2;
    localparam logic [2:0] BL_8  = 3'h3;
    localparam logic [2:0] CL_2  = 3'h2;
    localparam logic [2:0] CL_3  = 3'h3;
    localparam logic [2:0] CL_25 = 3'h6;

    // reset values: burst of 4, sequential, latency 2, dll on
    localparam logic [ADDR_W-1:0] MODE_RESET   = 13'h0022;
    localparam logic              DLL_ON_RESET = 1'b1;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_PRE_DOWN,
        PWR_ACT_DOWN,
        PWR_SELF
    } pwr_state_e;

endpackage

// [design/ddr_burst_mem.sv]
`timescale 1ns/1ns
`default_nettype none

module ddr_burst_mem
    import ddr_cmd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wrEnA,
    input  wire logic [MEM_AW-1:0] wrAddrA,
    input  wire logic [DQ_W-1:0]   wrDataA,
    input  wire logic [1:0]        byteEnA,
    input  wire logic              wrEnB,
    input  wire logic [MEM_AW-1:0] wrAddrB,
    input  wire logic [DQ_W-1:0]   wrDataB,
    input  wire logic [1:0]        byteEnB,
    input  wire logic [MEM_AW-1:0] rdAddrA,
    input  wire logic [MEM_AW-1:0] rdAddrB,
    output logic      [DQ_W-1:0]   rdDataA,
    output logic      [DQ_W-1:0]   rdDataB
);

    logic [DQ_W-1:0] store [0:(1<<MEM_AW)-1];

    // two element writes per clock, each byte lane on its own enable
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (wrEnA && byteEnA[i]) begin
                store[wrAddrA][i*8 +: 8] <= wrDataA[i*8 +: 8];
            end
            if (wrEnB && byteEnB[i]) begin
                store[wrAddrB][i*8 +: 8] <= wrDataB[i*8 +: 8];
            end
        end
    end

    // registered reads, one element pair per clock
    always_ff @(posedge clk) begin
        rdDataA <= store[rdAddrA];
        rdDataB <= store[rdAddrB];
    end

endmodule

`default_nettype wire

// [tb/ddr_sdram_command_timing_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module ddr_sdram_command_timing_checker
    import ddr_cmd_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                reset,
    input wire logic                ck,
    input wire logic                cke,
    input wire logic                dqOe,
    input wire logic                dqsOut,
    input wire logic                dqsOe,
    input wire logic [BANKS-1:0]    bankOpenSys,
    input wire logic                prePowerDownSys,
    input wire logic                actPowerDownSys,
    input wire logic                selfRefreshSys,
    input wire logic [REFCNT_W-1:0] refreshCount
);
    // read side: strobe tracks ck, behind a one-cycle preamble
    strobe_follows_a: assert property (
        @(negedge ck) disable iff (reset) dqOe |-> dqsOut == ck)
        else $error("read strobe does not follow ck");
    strobe_preamble_a: assert property (
        @(posedge ck) disable iff (reset) $rose(dqOe) |-> $past(dqsOe))
        else $error("read data without strobe preamble");
    strobe_enable_a: assert property (
        @(posedge clk_sys) disable iff (reset) dqOe |-> dqsOe)
        else $error("data driven while strobe released");
    // power state against open rows
    power_onehot_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        $onehot0({prePowerDownSys, actPowerDownSys, selfRefreshSys}))
        else $error("two power states at once");
    act_pd_open_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        actPowerDownSys |-> bankOpenSys != 4'h0)
        else $error("active power-down with no open row");
    pre_pd_idle_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        prePowerDownSys |-> bankOpenSys == 4'h0)
        else $error("precharge power-down with a row open");
    self_idle_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        selfRefreshSys |-> bankOpenSys == 4'h0)
        else $error("self refresh with a row open");
    // a long run of high cke must have ended every low-power state
    run_on_cke_a: assert property (
        @(posedge clk_sys) disable iff (reset) cke [*8]
        |-> !(prePowerDownSys || actPowerDownSys || selfRefreshSys))
        else $error("low-power state with cke high");
    // refresh count moves in single steps and clears in reset
    refresh_step_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        refreshCount != $past(refreshCount)
        |-> refreshCount == $past(refreshCount) + 16'h0001)
        else $error("refresh count jumped");
    reset_clear_a: assert property (
        @(posedge clk_sys) reset
        |=> refreshCount == 16'h0000 && bankOpenSys == 4'h0)
        else $error("status not cleared by reset");
    // main scenarios reached
    cover property (@(posedge ck) $rose(dqOe));
    cover property (@(posedge clk_sys) actPowerDownSys);
    cover property (@(posedge clk_sys) prePowerDownSys);
    cover property (@(posedge clk_sys) selfRefreshSys);
endmodule

bind ddr_sdram_command_timing ddr_sdram_command_timing_checker chk (
    .clk_sys, .reset, .ck, .cke, .dqOe, .dqsOut, .dqsOe, .bankOpenSys,
    .prePowerDownSys, .actPowerDownSys, .selfRefreshSys, .refreshCount
);

`default_nettype wire

// [tb/ddr_ctl_model.sv]
`timescale 1ns/1ns
`default_nettype none

module ddr_ctl_model
    import ddr_cmd_pkg::*;
(
    input  wire logic            ck,
    input  wire logic [DQ_W-1:0] dqOut,
    input  wire logic            dqOe,
    output logic                 cke,
    output logic                 csN,
    output logic                 rasN,
    output logic                 casN,
    output logic                 weN,
    output logic [1:0]           ba,
    output logic [ADDR_W-1:0]    addr,
    output logic                 upperByteMask,
    output logic                 lowerByteMask,
    output logic [DQ_W-1:0]      dqIn,
    output logic                 dqsIn
);
    // power-up: cke low and nop on the pins
    initial begin
        {cke, csN, rasN, casN, weN} = {2'h0, CMD_NOP};
        {ba, addr, dqIn} = '0;
        {upperByteMask, lowerByteMask, dqsIn} = 3'h0;
    end

    // one command for one ck cycle; entered just after a rising edge
    task automatic cmd(input logic [2:0] c, input logic [1:0] b,
                       input logic [ADDR_W-1:0] a, input logic k);
        // one idle edge first, so no pin is driven twice in a step
        @(posedge ck);
        #5;
        {csN, rasN, casN, weN} = {1'b0, c};
        {ba, addr, cke} = {b, a, k};
        @(posedge ck);
        #5;
        {rasN, casN, weN} = CMD_NOP;
        addr = ~addr; // released lines must not look valid
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ck);
        #5;
    endtask

    // even element before the rising edge, odd before the falling one
    task automatic wr(input logic [1:0] b, input logic [COL_W-1:0] col,
                      input logic [4*DQ_W-1:0] d, input logic [3:0] um,
                      input logic [3:0] lm);
        cmd(CMD_WR, b, ADDR_W'(col), 1'b1);
        for (int i = 0; i < 4; i++) begin
            if (i == 1 || i == 3) @(posedge ck);
            if (i == 2) @(negedge ck);
            if (i != 0) #5;
            dqIn = d[i*DQ_W +: DQ_W];
            {upperByteMask, lowerByteMask} = {um[i], lm[i]};
            dqsIn = ~i[0];
        end
        @(negedge ck);
        #5;
        dqIn = ~dqIn;
        {upperByteMask, lowerByteMask} = ~{upperByteMask, lowerByteMask};
        @(posedge ck);
        #5;
    endtask

    // collect elements mid-phase while the device drives
    task automatic rd(input logic [1:0] b, input logic [ADDR_W-1:0] a,
                      output logic [8*DQ_W-1:0] q, output int n);
        q = '0;
        n = 0;
        cmd(CMD_RD, b, a, 1'b1);
        repeat (14) begin
            @(ck);
            #20;
            if (dqOe === 1'b1 && n < 8) begin
                q[n*DQ_W +: DQ_W] = dqOut;
                n++;
            end
        end
        @(posedge ck);
        #5;
    endtask
endmodule

`default_nettype wire

// [tb/test_ddr_sdram_command_timing.sv]
`timescale 1ns/1ns
`default_nettype none

module test_ddr_sdram_command_timing import ddr_cmd_pkg::*;;
    logic                clk_sys, reset, ck, cke, csN, rasN, casN, weN;
    logic                upperByteMask, lowerByteMask, dqsIn;
    logic [1:0]          ba;
    logic [ADDR_W-1:0]   addr;
    logic [DQ_W-1:0]     dqIn, dqOut;
    logic                dqOe, dqsOut, dqsOe, dllEnabledSys;
    logic                prePowerDownSys, actPowerDownSys, selfRefreshSys;
    logic [BANKS-1:0]    bankOpenSys;
    logic [REFCNT_W-1:0] refreshCount;
    int                  n_fail = 0;
    int                  n_compared = 0;

    ddr_sdram_command_timing dut (
        .clk_sys, .reset, .ck, .cke, .csN, .rasN, .casN, .weN, .ba, .addr,
        .upperByteMask, .lowerByteMask, .dqIn, .dqOut, .dqOe, .dqsIn,
        .dqsOut, .dqsOe, .bankOpenSys, .prePowerDownSys, .actPowerDownSys,
        .selfRefreshSys, .dllEnabledSys, .refreshCount
    );
    ddr_ctl_model ctl (
        .ck, .dqOut, .dqOe, .cke, .csN, .rasN, .casN, .weN, .ba, .addr,
        .upperByteMask, .lowerByteMask, .dqIn, .dqsIn
    );

    // link clock offset so its edges never meet the system clock's
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        ck = 1'b0;
        #7;
        forever #40 ck = ~ck;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask

    // status crosses in 2 ck plus up to 2 system clocks
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        @(posedge ck);
        #5;
    endtask

    task automatic t_init();
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b1);
        ctl.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1);
        ctl.cmd(CMD_MRS, EMRS_BANK, 13'h0001, 1'b1);
        ctl.cmd(CMD_MRS, MRS_BANK, 13'h0022, 1'b1);
        settle();
        chk(dllEnabledSys, 0);
        ctl.cmd(CMD_MRS, EMRS_BANK, 13'h0000, 1'b1);
        ctl.cmd(CMD_REF, 2'h0, '0, 1'b1);
        ctl.idle(5);
        ctl.cmd(CMD_REF, 2'h0, '0, 1'b1);
        settle();
        chk(dllEnabledSys, 1);
        chk(refreshCount, 2);
    endtask

    // write at column 2, masked rewrite at column 0, read back
    task automatic t_write_read();
        logic [8*DQ_W-1:0] q;
        int                n;
        ctl.cmd(CMD_ACT, 2'h1, 13'h0055, 1'b1);
        settle();
        chk(bankOpenSys, 4'h2);
        ctl.wr(2'h1, 3'h2, 64'h4d4c_3b3a_2928_1716, 4'h0, 4'h0);
        ctl.wr(2'h1, 3'h0, 64'hd4c4_b3a3_9282_7161, 4'h8, 4'h2);
        ctl.rd(2'h1, 13'h0400, q, n);
        chk(n, 4);
        chk(q[63:0], 64'h29c4_b3a3_924c_7161);
        settle();
        chk(bankOpenSys, 4'h0);
        ctl.rd(2'h1, 13'h0000, q, n);
        chk(n, 0);
    endtask

    task automatic t_power();
        ctl.cmd(CMD_ACT, 2'h0, 13'h0011, 1'b1);
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b0);
        settle();
        chk({actPowerDownSys, prePowerDownSys}, 2'h2);
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b1);
        ctl.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1);
        ctl.idle(2);
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b0);
        settle();
        chk({actPowerDownSys, prePowerDownSys}, 2'h1);
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b1);
        settle();
        chk({actPowerDownSys, prePowerDownSys}, 2'h0);
    endtask

    task automatic t_self_refresh();
        ctl.cmd(CMD_REF, 2'h0, '0, 1'b0);
        settle();
        chk(selfRefreshSys, 1);
        ctl.cmd(CMD_NOP, 2'h0, '0, 1'b1);
        ctl.idle(4);
        settle();
        chk(selfRefreshSys, 0);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // reset for 8 system clocks, then the scenarios in turn
    initial begin
        reset = 1'b1;
        repeat (8) @(posedge clk_sys);
        #5;
        reset = 1'b0;
        @(posedge ck);
        #5;
        ctl.idle(4);
        t_init();
        t_write_read();
        t_power();
        t_self_refresh();
        tally_and_finish();
    end

    // a hang counts as a failure
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
